// ### dv/acs_ana_model.sv
// Purpose: analog core stand-in that returns a held sample
// Assumes: level is chosen by the bench before each conversion
// Notes:   unpowered output toggles so stale codes never look valid
`timescale 1ns/1ps
module acs_ana_model
(
  input  wire logic        core_clk,
  input  wire logic        anaPowerOn,
  input  wire logic        anaSample,
  input  wire logic [11:0] level,
  output logic [11:0]      rawData
);
  // track the input while sampling, hold it during the bit trials
  always @(posedge core_clk)
  begin
    if (!anaPowerOn)
      rawData <= ~rawData;
    else if (anaSample)
      rawData <= level;
  end
endmodule

// ### dv/adc_conversion_sequencer_test.sv
// Purpose: self-checking bench for the conversion sequencer
// Assumes: unity gain trim, single-ended mode, non-amplified channel
// Notes:   trigger inputs other than software are tied low
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
  import acs_pkg::*;
  logic core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic pready, pslverr, anaPowerOn, anaSample, convIrq, err;
  logic convActiveOut, portLineTwo;
  logic [11:0] lvl = 0, rawData;
  int failures = 0, n_checks = 0, cycles = 0, irqs = 0, convs = 0;
  int dv = 0, av = 0, ex = 0;
  logic [3:0] strb = 4'hF;
  int unsigned seed = 54475;
  int q[$];

  acs_sequencer dut_u (.core_clk(core_clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .convstPin(1'b0), .timer0Evt(1'b0), .timer1Evt(1'b0), .plaEvt(1'b0),
    .pwmEvt(1'b0), .rawData(rawData), .anaPowerOn(anaPowerOn),
    .anaInputMode(), .anaPosBypass(), .anaNegBypass(), .anaPosSel(),
    .anaNegSel(), .anaAmpGain(), .anaSample(anaSample), .convTick(),
    .convIrq(convIrq), .convActiveOut(convActiveOut),
    .portLineTwo(portLineTwo));
  acs_ana_model ana_u (.core_clk(core_clk), .anaPowerOn(anaPowerOn),
    .anaSample(anaSample), .level(lvl), .rawData(rawData));

  always #20 core_clk = ~core_clk;
  // watchdog: the whole run needs well under 5000 cycles
  always @(posedge core_clk)
  begin
    cycles++;
    irqs += (convIrq === 1'b1);
    if (cycles == 20000)
    begin
      failures++;
      stop_test();
    end
  end

  function automatic logic [11:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[11:0];
  endfunction

  task automatic stop_test();
    if (failures == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, got);
    n_checks++;
    if (got !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, got);
    end
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  // start one software conversion and time the active output
  task automatic conv(input logic [15:0] ctl, input int cyc);
    int n;
    int v;
    lvl <= rnd();
    apb(1'b1, OFF_CONTROL, {16'h0, ctl});
    for (n = 0; convActiveOut !== 1'b1 && n < 20; n++) @(posedge core_clk);
    chk("portLineTwo", 32'h1, {31'h0, portLineTwo});
    for (n = 0; convActiveOut === 1'b1 && n < 3000; n++)
      @(posedge core_clk);
    chk("busyCycles", cyc, n);
    v = lvl + 5;
    q.push_back((v > 4095 ? 4095 : v) << 16);
    convs++;
  endtask

  task automatic getres();
    rdchk("result", OFF_RESULT, q.pop_front());
  endtask

  initial
  begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    rdchk("control", OFF_CONTROL, 32'h0A00);
    rdchk("gainTrim", OFF_GAIN_TRIM, 32'h800);
    apb(1'b1, OFF_POS_SEL, 32'h2);
    apb(1'b1, OFF_OFFS_TRIM, 32'h5);
    apb(1'b1, OFF_OUT_FUNC, 32'h1);
    conv(16'h0AA3, 54);
    rdchk("status", OFF_STATUS, 32'h1);
    rdchk("ctlType", OFF_CONTROL, 32'h0AA0);
    getres();
    rdchk("statusClr", OFF_STATUS, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      dv = i % 3;
      av = rnd() % 3;
      // busy span is the divider times (acquisition clocks plus 19)
      ex = (1 << dv) * ((2 << av) + 19);
      conv({2'h0, 3'(dv), 3'(av), 8'hA3}, ex);
      getres();
    end
    apb(1'b1, OFF_POS_SEL, 32'h10);
    conv(16'h0AA3, 1120);
    getres();
    apb(1'b1, OFF_POS_SEL, 32'h2);
    conv(16'h0AA3, 54);
    getres();
    chk("irqCount", convs, irqs);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmappedErr", 32'h1, {31'h0, err});
    // only byte lane 0 of the gain trim is written
    strb <= 4'h1;
    apb(1'b1, OFF_GAIN_TRIM, 32'hFFF);
    strb <= 4'hF;
    rdchk("gainLane0", OFF_GAIN_TRIM, 32'h8FF);
    apb(1'b1, OFF_RESET, 32'h0);
    rdchk("offsAfterReset", OFF_OFFS_TRIM, 32'h0);
    rdchk("gainAfterReset", OFF_GAIN_TRIM, 32'h800);
    rdchk("ctlAfterReset", OFF_CONTROL, 32'h0A00);
    stop_test();
  end
endmodule

// ### rtl/acs_pkg.sv
// Purpose: shared constants for the converter sequencer
// Assumes: 32-bit APB register window, one word per register
// Notes:   offsets, field positions, reset values and counts live here
package acs_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFF_CONTROL   = 8'h00;
  localparam logic [7:0] OFF_POS_SEL   = 8'h04;
  localparam logic [7:0] OFF_NEG_SEL   = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0C;
  localparam logic [7:0] OFF_RESULT    = 8'h10;
  localparam logic [7:0] OFF_RESET     = 8'h14;
  localparam logic [7:0] OFF_GAIN_TRIM = 8'h18;
  localparam logic [7:0] OFF_OFFS_TRIM = 8'h1C;
  localparam logic [7:0] OFF_AMP_GAIN  = 8'h20;
  localparam logic [7:0] OFF_OUT_FUNC  = 8'h24;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTL_POS_BYP = 15;
  localparam int CTL_NEG_BYP = 14;
  localparam int CTL_DIV_LSB = 11;
  localparam int CTL_ACQ_LSB = 8;
  localparam int CTL_ENABLE  = 7;
  localparam int CTL_POWER   = 5;
  localparam int CTL_MODE_LSB = 3;
  localparam int CTL_TYPE_LSB = 0;
  localparam logic [15:0] CTL_RST      = 16'h0A00;
  localparam logic [15:0] CTL_WR_MASK  = 16'hFFBF;

  // conversion mode codes
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_DIFF   = 2'h1;
  localparam logic [1:0] MODE_PSEUDO = 2'h2;

  // trigger type codes
  localparam logic [2:0] TRIG_PIN    = 3'h0;
  localparam logic [2:0] TRIG_TMR1   = 3'h1;
  localparam logic [2:0] TRIG_TMR0   = 3'h2;
  localparam logic [2:0] TRIG_SW_ONE = 3'h3;
  localparam logic [2:0] TRIG_SW_RUN = 3'h4;
  localparam logic [2:0] TRIG_PLA    = 3'h5;
  localparam logic [2:0] TRIG_PWM    = 3'h6;

  // ---------------------------------------------------------------
  // timing and trim constants
  // ---------------------------------------------------------------
  localparam logic [6:0] TRIAL_CLKS   = 7'h13;  // bit trials plus write
  localparam logic [2:0] TEMP_ACQ_CODE = 3'h3;  // 16 clocks
  localparam logic [2:0] TEMP_DIV_CODE = 3'h5;  // divide by 32
  localparam logic [11:0] GAIN_RST    = 12'h800; // unity, 1.11 format
  localparam logic [11:0] OFFS_RST    = 12'h000;
  localparam logic [4:0]  AMP_RST     = 5'h00;
  localparam logic [4:0]  SEL_RST     = 5'h00;
  localparam logic [4:0]  AMP_CH0     = 5'h00;  // amplified input zero
  localparam logic [4:0]  AMP_CH1     = 5'h01;  // amplified input one
  localparam int          RES_LSB     = 16;

  // sequencer states, gray along idle-acquire-trial
  typedef enum logic [1:0] {
    ACS_IDLE  = 2'b00,
    ACS_ACQ   = 2'b01,
    ACS_TRIAL = 2'b11
  } acs_state_t;

endpackage

// ### rtl/acs_sequencer.sv
// Purpose: conversion sequencer and register set of a 12-bit converter
// Assumes: APB slave, zero wait states; raw result from the core is
//          stable when the trial phase ends
// Notes:   converter clock is an enable made from core_clk
`timescale 1ns/1ps

// Functional notes
// - reset gives eight acquisition clocks and divide by two
// - conversion lasts acquisition clocks plus 19 further converter clocks
// - temperature channel forces 16 acquisition clocks and divide by 32
// - user timing returns after the temperature result is read
// - each completion sets ready bit 0 and raises the interrupt
// - reading the result register clears the ready flag
// - active output high through the whole conversion, then low
// - active output mirrored on port line when function select allows
// - each 12-bit result is stored for software
// - writing the reset register restores all register defaults
// - control holds power, input mode and trigger type
// - positive and negative inputs come from separate select registers
// - gain trim only for channels without the amplifier
// - offset trim applies to every channel
// - a register sets the gain of both amplified inputs
// - result in bits 27..16, four sign bits above in differential mode, else zero
// - divider codes 000..101 give 1..32, default 001
// - acquisition codes 000..101 give 2..64 clocks
// - single software type returns to 000 after its conversion
module acs_sequencer
  import acs_pkg::*;
#(
  parameter logic [4:0] TEMP_CHANNEL = 5'h10
)
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        convstPin,
  input  wire logic        timer0Evt,
  input  wire logic        timer1Evt,
  input  wire logic        plaEvt,
  input  wire logic        pwmEvt,
  input  wire logic [11:0] rawData,
  output logic             anaPowerOn,
  output logic [1:0]       anaInputMode,
  output logic             anaPosBypass,
  output logic             anaNegBypass,
  output logic [4:0]       anaPosSel,
  output logic [4:0]       anaNegSel,
  output logic [4:0]       anaAmpGain,
  output logic             anaSample,
  output logic             convTick,
  output logic             convIrq,
  output logic             convActiveOut,
  output logic             portLineTwo
);

  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [31:0] mergeBytes(input logic [31:0] oldV,
                                             input logic [31:0] newV,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = oldV;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        res[i*8 +: 8] = newV[i*8 +: 8];
    return res;
  endfunction

  // acquisition clocks: 2 << code, codes above 5 read as 64
  function automatic logic [6:0] acqClocks(input logic [2:0] code);
    return (code > 3'h5) ? 7'h40 : 7'(7'h02 << code);
  endfunction

  // offset always, gain only when asked, then clamp to the code range
  function automatic logic [11:0] trimResult(input logic [11:0] raw,
                                             input logic [11:0] gain,
                                             input logic [11:0] offs,
                                             input logic        useGain,
                                             input logic        signedMode);
    logic signed [27:0] acc;
    logic signed [27:0] lo;
    logic signed [27:0] hi;
    acc = signedMode ? 28'(signed'(raw)) : 28'({16'h0000, raw});
    // gain is made signed so a negative differential code keeps its sign
    if (useGain)
      acc = (acc * signed'(28'({16'h0000, gain}))) >>> 11;
    acc = acc + 28'(signed'(offs));
    lo  = signedMode ? -28'sd2048 : 28'sd0;
    hi  = signedMode ? 28'sd2047 : 28'sd4095;
    if (acc < lo)
      acc = lo;
    else if (acc > hi)
      acc = hi;
    return acc[11:0];
  endfunction

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  acs_state_t  state_r,   state_nxt;
  logic [15:0] ctrl_r,    ctrl_nxt;
  logic [4:0]  posSel_r,  posSel_nxt;
  logic [4:0]  negSel_r,  negSel_nxt;
  logic [11:0] gain_r,    gain_nxt;
  logic [11:0] offs_r,    offs_nxt;
  logic [4:0]  amp_r,     amp_nxt;
  logic        outFn_r,   outFn_nxt;
  logic        ready_r,   ready_nxt;
  logic [31:0] result_r,  result_nxt;
  logic        busy_r,    busy_nxt;
  logic        irq_r,     irq_nxt;
  logic        tempHold_r, tempHold_nxt;
  logic [2:0]  useDiv_r,  useDiv_nxt;
  logic [6:0]  useAcq_r,  useAcq_nxt;
  logic [6:0]  cnt_r,     cnt_nxt;
  logic [31:0] prdata_r,  prdata_nxt;
  logic        capRdy_r,  capRdy_nxt;
  logic [1:0]  pinSync_r;
  logic [11:0] rawS1_r;
  logic [11:0] rawS2_r;

  logic        wrAcc;
  logic        rdAcc;
  logic        mapped;
  logic        startNow;
  logic        trigHit;
  logic        finish;
  logic        tick;
  logic        isTemp;
  logic [11:0] trimmed;
  logic        diffMode;

  // -------------------------------------------------------------
  // pin and raw data synchronisers
  // -------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinSync_r <= 2'b00;
      rawS1_r   <= 12'h000;
      rawS2_r   <= 12'h000;
    end
    else
    begin
      pinSync_r <= {pinSync_r[0], convstPin};
      rawS1_r   <= rawData;
      rawS2_r   <= rawS1_r;
    end
  end

  // -------------------------------------------------------------
  // converter clock enable
  // -------------------------------------------------------------
  acs_tick_gen u_tick (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .restart  (startNow),
    .divCode  (useDiv_r),
    .tick     (tick)
  );

  // -------------------------------------------------------------
  // decode and trigger selection
  // -------------------------------------------------------------
  always_comb
  begin
    wrAcc    = psel && penable && pwrite;
    rdAcc    = psel && penable && !pwrite;
    mapped   = (paddr[1:0] == 2'b00) && (paddr <= OFF_OUT_FUNC);
    diffMode = (ctrl_r[CTL_MODE_LSB +: 2] == MODE_DIFF);
    isTemp   = (posSel_r == TEMP_CHANNEL);
    case (ctrl_r[CTL_TYPE_LSB +: 3])
      TRIG_PIN:    trigHit = pinSync_r[1];
      TRIG_TMR1:   trigHit = timer1Evt;
      TRIG_TMR0:   trigHit = timer0Evt;
      TRIG_SW_ONE: trigHit = 1'b1;
      TRIG_SW_RUN: trigHit = 1'b1;
      TRIG_PLA:    trigHit = plaEvt;
      TRIG_PWM:    trigHit = pwmEvt;
      default:     trigHit = 1'b0;
    endcase
    startNow = (state_r == ACS_IDLE) && trigHit && ctrl_r[CTL_ENABLE]
               && ctrl_r[CTL_POWER];
    finish   = (state_r == ACS_TRIAL) && tick
               && (cnt_r == TRIAL_CLKS - 7'h01);
    trimmed  = trimResult(rawS2_r, gain_r, offs_r,
                 !((posSel_r == AMP_CH0) || (posSel_r == AMP_CH1)),
                 diffMode);
  end

  // -------------------------------------------------------------
  // sequencer and register next values
  // -------------------------------------------------------------
  // timing is latched at start so a mid-conversion control write cannot
  // stretch or cut the running conversion
  always_comb
  begin
    state_nxt    = state_r;
    cnt_nxt      = cnt_r;
    useDiv_nxt   = useDiv_r;
    useAcq_nxt   = useAcq_r;
    tempHold_nxt = tempHold_r;
    busy_nxt     = busy_r;
    irq_nxt      = 1'b0;
    ready_nxt    = ready_r;
    result_nxt   = result_r;
    ctrl_nxt     = ctrl_r;
    posSel_nxt   = posSel_r;
    negSel_nxt   = negSel_r;
    gain_nxt     = gain_r;
    offs_nxt     = offs_r;
    amp_nxt      = amp_r;
    outFn_nxt    = outFn_r;
    capRdy_nxt   = capRdy_r;
    prdata_nxt   = prdata_r;

    // read capture in setup phase, side effects on the access edge
    if (psel && !penable && !pwrite)
    begin
      capRdy_nxt = ready_r;
      case (paddr)
        OFF_CONTROL:   prdata_nxt = {16'h0000, ctrl_r};
        OFF_POS_SEL:   prdata_nxt = {27'h0, posSel_r};
        OFF_NEG_SEL:   prdata_nxt = {27'h0, negSel_r};
        OFF_STATUS:    prdata_nxt = {31'h0, ready_r};
        OFF_RESULT:    prdata_nxt = result_r;
        OFF_GAIN_TRIM: prdata_nxt = {20'h0, gain_r};
        OFF_OFFS_TRIM: prdata_nxt = {20'h0, offs_r};
        OFF_AMP_GAIN:  prdata_nxt = {27'h0, amp_r};
        OFF_OUT_FUNC:  prdata_nxt = {31'h0, outFn_r};
        default:       prdata_nxt = 32'h0000_0000;
      endcase
    end

    // only a flag already seen by the read is cleared, so a result
    // landing between setup and access is never lost
    if (rdAcc && (paddr == OFF_RESULT))
    begin
      if (capRdy_r)
        ready_nxt = 1'b0;
      tempHold_nxt = 1'b0;
    end

    case (state_r)
      ACS_IDLE:
      begin
        if (startNow)
        begin
          state_nxt = ACS_ACQ;
          cnt_nxt   = 7'h00;
          busy_nxt  = 1'b1;
          if (isTemp || tempHold_r)
          begin
            useDiv_nxt   = TEMP_DIV_CODE;
            useAcq_nxt   = acqClocks(TEMP_ACQ_CODE);
            tempHold_nxt = isTemp || tempHold_r;
          end
          else
          begin
            useDiv_nxt = ctrl_r[CTL_DIV_LSB +: 3];
            useAcq_nxt = acqClocks(ctrl_r[CTL_ACQ_LSB +: 3]);
          end
        end
      end
      ACS_ACQ:
      begin
        if (tick)
        begin
          if (cnt_r == useAcq_r - 7'h01)
          begin
            state_nxt = ACS_TRIAL;
            cnt_nxt   = 7'h00;
          end
          else
            cnt_nxt = cnt_r + 7'h01;
        end
      end
      ACS_TRIAL:
      begin
        if (finish)
        begin
          state_nxt  = ACS_IDLE;
          busy_nxt   = 1'b0;
          ready_nxt  = 1'b1;
          irq_nxt    = 1'b1;
          result_nxt = {{4{diffMode & trimmed[11]}}, trimmed,
                        16'h0000};
          if (ctrl_r[CTL_TYPE_LSB +: 3] == TRIG_SW_ONE)
            ctrl_nxt[CTL_TYPE_LSB +: 3] = TRIG_PIN;
        end
        else if (tick)
          cnt_nxt = cnt_r + 7'h01;
      end
      default:
      begin
        state_nxt = ACS_IDLE;
        busy_nxt  = 1'b0;
      end
    endcase

    // register writes; software wins over the single-shot type clear
    if (wrAcc)
    begin
      case (paddr)
        OFF_CONTROL:
          ctrl_nxt = 16'(mergeBytes({16'h0000, ctrl_r}, pwdata, pstrb))
                     & CTL_WR_MASK;
        OFF_POS_SEL:
          if (pstrb[0]) posSel_nxt = pwdata[4:0];
        OFF_NEG_SEL:
          if (pstrb[0]) negSel_nxt = pwdata[4:0];
        OFF_GAIN_TRIM:
          gain_nxt = 12'(mergeBytes({20'h0, gain_r}, pwdata, pstrb));
        OFF_OFFS_TRIM:
          offs_nxt = 12'(mergeBytes({20'h0, offs_r}, pwdata, pstrb));
        OFF_AMP_GAIN:
          if (pstrb[0]) amp_nxt = pwdata[4:0];
        OFF_OUT_FUNC:
          if (pstrb[0]) outFn_nxt = pwdata[0];
        OFF_RESET:
        begin
          // full return to defaults, an active conversion is dropped
          ctrl_nxt     = CTL_RST;
          posSel_nxt   = SEL_RST;
          negSel_nxt   = SEL_RST;
          gain_nxt     = GAIN_RST;
          offs_nxt     = OFFS_RST;
          amp_nxt      = AMP_RST;
          outFn_nxt    = 1'b0;
          ready_nxt    = 1'b0;
          result_nxt   = 32'h0000_0000;
          tempHold_nxt = 1'b0;
          state_nxt    = ACS_IDLE;
          busy_nxt     = 1'b0;
          irq_nxt      = 1'b0;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r    <= ACS_IDLE;
      ctrl_r     <= CTL_RST;
      posSel_r   <= SEL_RST;
      negSel_r   <= SEL_RST;
      gain_r     <= GAIN_RST;
      offs_r     <= OFFS_RST;
      amp_r      <= AMP_RST;
      outFn_r    <= 1'b0;
      ready_r    <= 1'b0;
      result_r   <= 32'h0000_0000;
      busy_r     <= 1'b0;
      irq_r      <= 1'b0;
      tempHold_r <= 1'b0;
      useDiv_r   <= 3'h1;
      useAcq_r   <= 7'h08;
      cnt_r      <= 7'h00;
      prdata_r   <= 32'h0000_0000;
      capRdy_r   <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      ctrl_r     <= ctrl_nxt;
      posSel_r   <= posSel_nxt;
      negSel_r   <= negSel_nxt;
      gain_r     <= gain_nxt;
      offs_r     <= offs_nxt;
      amp_r      <= amp_nxt;
      outFn_r    <= outFn_nxt;
      ready_r    <= ready_nxt;
      result_r   <= result_nxt;
      busy_r     <= busy_nxt;
      irq_r      <= irq_nxt;
      tempHold_r <= tempHold_nxt;
      useDiv_r   <= useDiv_nxt;
      useAcq_r   <= useAcq_nxt;
      cnt_r      <= cnt_nxt;
      prdata_r   <= prdata_nxt;
      capRdy_r   <= capRdy_nxt;
    end
  end

  // -------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------
  assign prdata        = prdata_r;
  assign pready        = 1'b1;
  assign pslverr       = psel && penable && !mapped;
  assign anaPowerOn    = ctrl_r[CTL_POWER];
  assign anaInputMode  = ctrl_r[CTL_MODE_LSB +: 2];
  assign anaPosBypass  = ctrl_r[CTL_POS_BYP];
  assign anaNegBypass  = ctrl_r[CTL_NEG_BYP];
  assign anaPosSel     = posSel_r;
  assign anaNegSel     = negSel_r;
  assign anaAmpGain    = amp_r;
  assign anaSample     = (state_r == ACS_ACQ);
  assign convTick      = tick;
  assign convIrq       = irq_r;
  assign convActiveOut = busy_r;
  assign portLineTwo   = busy_r & outFn_r;

  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  AST_RESET_TIMING: assert property (@(posedge core_clk)
    $rose(rst_n) |-> ctrl_r[13:8] == 6'h0A)
    else $error("control reset timing wrong");

  AST_TRIAL_LEN: assert property (@(posedge core_clk)
    disable iff (!rst_n || (wrAcc && paddr == OFF_RESET))
    $rose(state_r == ACS_TRIAL) && useDiv_r == 3'h0 |->
      (state_r == ACS_TRIAL)[*8] ##11 finish)
    else $error("trial phase length wrong");

  AST_TEMP_FORCE: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    startNow && isTemp |=> useDiv_r == 3'h5 && useAcq_r == 7'h10)
    else $error("temperature timing not forced");

  AST_TEMP_RESTORE: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    rdAcc && paddr == OFF_RESULT && !startNow |=> !tempHold_r)
    else $error("user timing not restored");

  AST_READY_SET: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    finish && !(wrAcc && paddr == OFF_RESET) |=> ready_r && convIrq)
    else $error("ready or interrupt missing");

  AST_READY_CLEAR: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    rdAcc && paddr == OFF_RESULT && capRdy_r && !finish |=> !ready_r)
    else $error("result read did not clear ready");

  AST_BUSY_SPAN: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    startNow && !wrAcc |=> convActiveOut && state_r == ACS_ACQ)
    else $error("active output not raised");

  AST_PORT_MIRROR: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    portLineTwo == (outFn_r && state_r != ACS_IDLE))
    else $error("port line mirror wrong");

  AST_RESET_REG: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    wrAcc && paddr == OFF_RESET |=> ctrl_r == CTL_RST && !ready_r
      && gain_r == GAIN_RST && !busy_r)
    else $error("reset register did not restore defaults");

  AST_SIGN_EXT: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    $changed(result_r) |-> result_r[15:0] == 16'h0000
      && result_r[31:28] == {4{result_r[27] & $past(diffMode)}})
    else $error("result layout wrong");

  AST_SINGLE_CLEAR: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    finish && ctrl_r[2:0] == TRIG_SW_ONE && !wrAcc |=> ctrl_r[2:0] == 3'h0)
    else $error("single conversion type not cleared");

  AST_FALL_WITH_READY: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    $fell(busy_r) && !$past(wrAcc) |-> $rose(ready_r) || ready_r)
    else $error("active output fell without result");

endmodule

// ### rtl/acs_tick_gen.sv
// Purpose: converter clock enable derived from the core clock
// Assumes: divider code 0..5 selects divide by 1..32
// Notes:   restart realigns the count so a conversion starts clean
`timescale 1ns/1ps
module acs_tick_gen
  import acs_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       restart,
  input  wire logic [2:0] divCode,
  output logic            tick
);

  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic [4:0] lastCnt;

  // -------------------------------------------------------------
  // divide count
  // -------------------------------------------------------------
  // codes above 5 are treated as divide by 32
  always_comb
  begin
    lastCnt = (divCode > 3'h5) ? 5'h1F : 5'((6'h01 << divCode) - 6'h01);
    tick    = (cnt_r == lastCnt);
    if (restart || tick)
      cnt_nxt = 5'h00;
    else
      cnt_nxt = cnt_r + 5'h01;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_r <= 5'h00;
    else
      cnt_r <= cnt_nxt;
  end

endmodule
